// file: hw/tec_timer_top.sv
// Purpose: Two 16-bit timer/event counters behind a classic Wishbone slave
// Assumes: 40 MHz system clock; asynchronous event pin; interrupt controller outside
// Notes: Counter 0 has timer, event and pulse width modes; counter 1 timer only
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`include "tec_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tec_timer_top
   import tec_pkg::*;
#(
   parameter int CTR0_DIV = `TEC_CTR0_DIV,
   parameter int CTR1_DIV = `TEC_CTR1_DIV
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic timer_event_pin_in,
   output logic ctr0_irq_out,
   output logic ctr1_irq_out,
   output logic wakeup_out
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] ctr0_control_reg, ctr0_control_next;
   logic [7:0] ctr1_control_reg, ctr1_control_next;
   logic [1:0] irq_en_reg, irq_en_next;
   logic [1:0] irq_flag_reg, irq_flag_next;
   logic power_down_reg, power_down_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] irq_out_reg, irq_out_next;
   logic wake_reg, wake_next;
   logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic [15:0] div0_reg, div0_next;
   logic [15:0] div1_reg, div1_next;
   logic tick0_reg, tick0_next;
   logic tick1_reg, tick1_next;
   tec_pw_state_t pw_state_reg, pw_state_next;
   tec_mode_t ctr0_mode;
   logic ctr0_run_enable, ctr1_run_enable, ctr0_edge_select;
   logic pin_rise, pin_fall, pin_active_edge, pin_return_edge;
   logic bus_req, wr_lane0, pw_clear_run;
   logic ctr0_inc, ctr0_running, ctr0_ovf;
   logic ctr1_inc, ctr1_ovf;
   logic [15:0] ctr0_count, ctr1_count;
   logic [7:0] ctr0_low_latch, ctr1_low_latch;
   logic c0_wr_lo, c0_wr_hi, c0_rd_hi, c1_wr_lo, c1_wr_hi, c1_rd_hi;

   assign ctr0_mode = tec_mode_t'(ctr0_control_reg[`TEC_MODE_HI_BIT:`TEC_MODE_LO_BIT]);
   assign ctr0_run_enable = ctr0_control_reg[`TEC_RUN_BIT];
   assign ctr1_run_enable = ctr1_control_reg[`TEC_RUN_BIT];
   assign ctr0_edge_select = ctr0_control_reg[`TEC_EDGE_BIT];

   // ----------------------------------------
   // Pin synchroniser and edge detect
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= timer_event_pin_in;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   assign pin_rise = pin_sync_reg && !pin_prev_reg;
   assign pin_fall = !pin_sync_reg && pin_prev_reg;
   assign pin_active_edge = ctr0_edge_select ? pin_rise : pin_fall;
   assign pin_return_edge = ctr0_edge_select ? pin_fall : pin_rise;

   // ----------------------------------------
   // Timer clock dividers
   // ----------------------------------------
   always_comb begin
      div0_next = div0_reg + 16'h0001;
      tick0_next = 1'b0;
      if (div0_reg >= 16'(CTR0_DIV - 1)) begin
         div0_next = 16'h0000;
         tick0_next = 1'b1;
      end
      div1_next = div1_reg + 16'h0001;
      tick1_next = 1'b0;
      if (div1_reg >= 16'(CTR1_DIV - 1)) begin
         div1_next = 16'h0000;
         tick1_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div0_reg <= 16'h0000;
         div1_reg <= 16'h0000;
         tick0_reg <= 1'b0;
         tick1_reg <= 1'b0;
      end else begin
         div0_reg <= div0_next;
         div1_reg <= div1_next;
         tick0_reg <= tick0_next;
         tick1_reg <= tick1_next;
      end
   end

   // ----------------------------------------
   // Pulse width sequencer
   // ----------------------------------------
   always_comb begin
      pw_state_next = pw_state_reg;
      pw_clear_run = 1'b0;
      unique case (pw_state_reg)
         TEC_PW_IDLE: begin
            if (ctr0_mode == TEC_MODE_PULSE && ctr0_run_enable) begin
               pw_state_next = TEC_PW_WAIT;
            end
         end
         TEC_PW_WAIT: begin
            if (ctr0_mode != TEC_MODE_PULSE || !ctr0_run_enable) begin
               pw_state_next = TEC_PW_IDLE;
            end else if (pin_active_edge) begin
               pw_state_next = TEC_PW_COUNT;
            end
         end
         TEC_PW_COUNT: begin
            if (ctr0_mode != TEC_MODE_PULSE || !ctr0_run_enable) begin
               pw_state_next = TEC_PW_IDLE;
            end else if (pin_return_edge) begin
               pw_state_next = TEC_PW_IDLE;
               pw_clear_run = 1'b1;
            end
         end
         default: begin
            pw_state_next = TEC_PW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pw_state_reg <= TEC_PW_IDLE;
      end else begin
         pw_state_reg <= pw_state_next;
      end
   end

   // ----------------------------------------
   // Counter increment selection
   // ----------------------------------------
   always_comb begin
      ctr0_inc = 1'b0;
      ctr0_running = 1'b0;
      unique case (ctr0_mode)
         TEC_MODE_TIMER: begin
            ctr0_running = ctr0_run_enable;
            ctr0_inc = tick0_reg;
         end
         TEC_MODE_EVENT: begin
            ctr0_running = ctr0_run_enable;
            ctr0_inc = ctr0_edge_select ? pin_fall : pin_rise;
         end
         TEC_MODE_PULSE: begin
            ctr0_running = ctr0_run_enable;
            ctr0_inc = tick0_reg && pw_state_reg == TEC_PW_COUNT;
         end
         TEC_MODE_UNUSED: begin
            ctr0_running = 1'b0;
            ctr0_inc = 1'b0;
         end
      endcase
      // Counter 1 only counts when its mode field holds the timer code
      ctr1_inc = tick1_reg && ctr1_control_reg[`TEC_MODE_HI_BIT:`TEC_MODE_LO_BIT] == TEC_MODE_TIMER;
   end

   // ----------------------------------------
   // Wishbone decode
   // ----------------------------------------
   assign bus_req = wb_cyc_in && wb_stb_in && !ack_reg;
   assign wr_lane0 = bus_req && wb_we_in && wb_sel_in[0];
   assign c0_wr_lo = wr_lane0 && wb_adr_in == `TEC_CTR0_COUNT_LOW_OFS;
   assign c0_wr_hi = wr_lane0 && wb_adr_in == `TEC_CTR0_COUNT_HIGH_OFS;
   assign c1_wr_lo = wr_lane0 && wb_adr_in == `TEC_CTR1_COUNT_LOW_OFS;
   assign c1_wr_hi = wr_lane0 && wb_adr_in == `TEC_CTR1_COUNT_HIGH_OFS;
   assign c0_rd_hi = bus_req && !wb_we_in && wb_adr_in == `TEC_CTR0_COUNT_HIGH_OFS;
   assign c1_rd_hi = bus_req && !wb_we_in && wb_adr_in == `TEC_CTR1_COUNT_HIGH_OFS;

   tec_counter16 #(
      .WIDTH(16)
   ) u_ctr0 (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .running_in(ctr0_running),
      .inc_in(ctr0_inc),
      .wr_low_in(c0_wr_lo),
      .wr_high_in(c0_wr_hi),
      .rd_high_in(c0_rd_hi),
      .wdata_in(wb_dat_in[7:0]),
      .count_out(ctr0_count),
      .low_latch_out(ctr0_low_latch),
      .ovf_out(ctr0_ovf)
   );

   tec_counter16 #(
      .WIDTH(16)
   ) u_ctr1 (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .running_in(ctr1_run_enable),
      .inc_in(ctr1_inc),
      .wr_low_in(c1_wr_lo),
      .wr_high_in(c1_wr_hi),
      .rd_high_in(c1_rd_hi),
      .wdata_in(wb_dat_in[7:0]),
      .count_out(ctr1_count),
      .low_latch_out(ctr1_low_latch),
      .ovf_out(ctr1_ovf)
   );

   // ----------------------------------------
   // Registers, flags and bus answers
   // ----------------------------------------
   always_comb begin
      ctr0_control_next = ctr0_control_reg;
      ctr1_control_next = ctr1_control_reg;
      irq_en_next = irq_en_reg;
      irq_flag_next = irq_flag_reg;
      power_down_next = power_down_reg;
      rdata_next = rdata_reg;
      ack_next = bus_req;
      if (wr_lane0) begin
         unique case (wb_adr_in)
            `TEC_CTR0_CONTROL_OFS: ctr0_control_next = wb_dat_in[7:0];
            `TEC_CTR1_CONTROL_OFS: ctr1_control_next = wb_dat_in[7:0];
            `TEC_IRQ_CTRL_OFS: begin
               irq_en_next = wb_dat_in[`TEC_IEN1_BIT:`TEC_IEN0_BIT];
               // Writing one clears a request flag
               irq_flag_next = irq_flag_reg & ~wb_dat_in[`TEC_IRQF1_BIT:`TEC_IRQF0_BIT];
            end
            `TEC_POWER_CTRL_OFS: power_down_next = wb_dat_in[`TEC_PDOWN_BIT];
            default: begin
            end
         endcase
      end
      if (pw_clear_run) begin
         ctr0_control_next[`TEC_RUN_BIT] = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (ctr0_ovf) begin
         irq_flag_next[0] = 1'b1;
      end
      if (ctr1_ovf) begin
         irq_flag_next[1] = 1'b1;
      end
      if (bus_req && !wb_we_in) begin
         unique case (wb_adr_in)
            `TEC_CTR0_CONTROL_OFS: rdata_next = {24'h000000, ctr0_control_reg};
            `TEC_CTR0_COUNT_LOW_OFS: rdata_next = {24'h000000, ctr0_low_latch};
            `TEC_CTR0_COUNT_HIGH_OFS: rdata_next = {24'h000000, ctr0_count[15:8]};
            `TEC_CTR1_CONTROL_OFS: rdata_next = {24'h000000, ctr1_control_reg};
            `TEC_CTR1_COUNT_LOW_OFS: rdata_next = {24'h000000, ctr1_low_latch};
            `TEC_CTR1_COUNT_HIGH_OFS: rdata_next = {24'h000000, ctr1_count[15:8]};
            `TEC_IRQ_CTRL_OFS: rdata_next = {26'h0000000, irq_flag_reg, 2'h0, irq_en_reg};
            `TEC_POWER_CTRL_OFS: rdata_next = {31'h00000000, power_down_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
      irq_out_next = irq_flag_next & irq_en_next;
      // Wake-up is independent of the interrupt enable
      wake_next = power_down_reg && ctr0_ovf && ctr0_mode == TEC_MODE_EVENT;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctr0_control_reg <= `TEC_CONTROL_RST;
         ctr1_control_reg <= `TEC_CONTROL_RST;
         irq_en_reg <= 2'h0;
         irq_flag_reg <= 2'h0;
         power_down_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         ack_reg <= 1'b0;
         irq_out_reg <= 2'h0;
         wake_reg <= 1'b0;
      end else begin
         ctr0_control_reg <= ctr0_control_next;
         ctr1_control_reg <= ctr1_control_next;
         irq_en_reg <= irq_en_next;
         irq_flag_reg <= irq_flag_next;
         power_down_reg <= power_down_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         irq_out_reg <= irq_out_next;
         wake_reg <= wake_next;
      end
   end

   assign wb_dat_out = rdata_reg;
   assign wb_ack_out = ack_reg;
   assign ctr0_irq_out = irq_out_reg[0];
   assign ctr1_irq_out = irq_out_reg[1];
   assign wakeup_out = wake_reg;
endmodule
`default_nettype wire

// file: shared/tec_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Wishbone classic slave with 32-bit data, byte addresses
// Notes: Included by the top and counter design files
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TEC_CTR0_CONTROL_OFS 8'h00
`define TEC_CTR0_COUNT_LOW_OFS 8'h04
`define TEC_CTR0_COUNT_HIGH_OFS 8'h08
`define TEC_CTR1_CONTROL_OFS 8'h0C
`define TEC_CTR1_COUNT_LOW_OFS 8'h10
`define TEC_CTR1_COUNT_HIGH_OFS 8'h14
`define TEC_IRQ_CTRL_OFS 8'h18
`define TEC_POWER_CTRL_OFS 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TEC_MODE_HI_BIT 7
`define TEC_MODE_LO_BIT 6
`define TEC_RUN_BIT 4
`define TEC_EDGE_BIT 3
// Interrupt control: enables in bits 1:0, sticky requests in bits 5:4
`define TEC_IEN0_BIT 0
`define TEC_IEN1_BIT 1
`define TEC_IRQF0_BIT 4
`define TEC_IRQF1_BIT 5
`define TEC_PDOWN_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TEC_CONTROL_RST 8'h00
`define TEC_COUNT_RST 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define TEC_SYS_CLK_HZ 40000000
`define TEC_CTR1_CLK_HZ 32768
`define TEC_CTR0_DIV 4
`define TEC_CTR1_DIV (`TEC_SYS_CLK_HZ / `TEC_CTR1_CLK_HZ)

`endif

// file: shared/tec_pkg.sv
// Purpose: Types shared by the timer/event counter design
// Assumes: Nothing beyond the register header
// Notes: Mode codes follow the two-bit operating mode field
package tec_pkg;
   typedef enum logic [1:0] {
      TEC_MODE_UNUSED = 2'h0,
      TEC_MODE_EVENT = 2'h1,
      TEC_MODE_TIMER = 2'h2,
      TEC_MODE_PULSE = 2'h3
   } tec_mode_t;

   typedef enum logic [2:0] {
      TEC_PW_IDLE = 3'b001,
      TEC_PW_WAIT = 3'b010,
      TEC_PW_COUNT = 3'b100
   } tec_pw_state_t;
endpackage

// file: hw/tec_counter16.sv
// Purpose: One 16-bit count-up counter with preload, auto-reload and byte access
// Assumes: Increment enable and bus strobes are one-cycle pulses on clk_sys_in
// Notes: Overflow is a one-cycle pulse on the increment that wraps FFFFh
`include "tec_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tec_counter16
   import tec_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic running_in,
   input wire logic inc_in,
   input wire logic wr_low_in,
   input wire logic wr_high_in,
   input wire logic rd_high_in,
   input wire logic [7:0] wdata_in,
   output logic [WIDTH-1:0] count_out,
   output logic [7:0] low_latch_out,
   output logic ovf_out
);
   logic [WIDTH-1:0] count_reg, count_next;
   logic [WIDTH-1:0] preload_reg, preload_next;
   logic [7:0] low_buf_reg, low_buf_next;
   logic [7:0] low_latch_reg, low_latch_next;
   logic ovf_reg, ovf_next;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      count_next = count_reg;
      preload_next = preload_reg;
      low_buf_next = low_buf_reg;
      low_latch_next = low_latch_reg;
      ovf_next = 1'b0;
      if (wr_low_in) begin
         low_buf_next = wdata_in;
      end
      if (rd_high_in) begin
         low_latch_next = count_reg[7:0];
      end
      if (wr_high_in) begin
         preload_next = {wdata_in, low_buf_reg};
         if (!running_in) begin
            count_next = {wdata_in, low_buf_reg};
         end
      end else if (inc_in && running_in) begin
         // Counting is inhibited during a preload write
         if (count_reg == {WIDTH{1'b1}}) begin
            count_next = preload_reg;
            ovf_next = 1'b1;
         end else begin
            count_next = count_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
         preload_reg <= '0;
         low_buf_reg <= 8'h00;
         low_latch_reg <= 8'h00;
         ovf_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         preload_reg <= preload_next;
         low_buf_reg <= low_buf_next;
         low_latch_reg <= low_latch_next;
         ovf_reg <= ovf_next;
      end
   end

   assign count_out = count_reg;
   assign low_latch_out = low_latch_reg;
   assign ovf_out = ovf_reg;
endmodule
`default_nettype wire

// file: verification/tec_timer_monitor.sv
// Purpose: Port-level checks on the timer top
// Assumes: Sees only top-level ports
// Notes: Shadows follow control writes at the edge that takes them, as the design does
`timescale 1ns/10ps
`default_nettype none
module tec_timer_monitor
   import tec_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic timer_event_pin_in,
   input wire logic ctr0_irq_out,
   input wire logic ctr1_irq_out,
   input wire logic wakeup_out
);
   logic [7:0] c0_reg, c0_next, c1_reg, c1_next, ie_reg, ie_next, pd_reg, pd_next;
   logic wr_ok, ev_pd, rd_ok, rd_c0;
   assign wr_ok = !wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0];
   assign rd_ok = wb_ack_out && !wb_we_in;
   assign rd_c0 = rd_ok && wb_adr_in == 8'h00 && c0_reg[7:6] != 2'b11;
   assign ev_pd = pd_reg[0] && (c0_reg[7:6] == 2'b01);
   always_comb begin
      c0_next = c0_reg;
      c1_next = c1_reg;
      ie_next = ie_reg;
      pd_next = pd_reg;
      if (wr_ok) begin
         case (wb_adr_in)
            8'h00: c0_next = wb_dat_in[7:0];
            8'h0C: c1_next = wb_dat_in[7:0];
            8'h18: ie_next = wb_dat_in[7:0];
            8'h1C: pd_next = wb_dat_in[7:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c0_reg <= 8'h00;
         c1_reg <= 8'h00;
         ie_reg <= 8'h00;
         pd_reg <= 8'h00;
      end else begin
         c0_reg <= c0_next;
         c1_reg <= c1_next;
         ie_reg <= ie_next;
         pd_reg <= pd_next;
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   ack_once_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
   ack_timely_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
   ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack unasked");
   rd_upper_a: assert property (rd_ok |-> wb_dat_out[31:8] == 24'h0) else $error("upper read bits set");
   unmapped_rd_a: assert property (rd_ok && wb_adr_in > 8'h1C |-> wb_dat_out == 32'h0) else $error("hole read");
   irq0_gate_a: assert property (ctr0_irq_out |-> ie_reg[0] || $past(ie_reg[0]))
      else $error("irq0 masked");
   irq1_gate_a: assert property (ctr1_irq_out |-> ie_reg[1] || $past(ie_reg[1]))
      else $error("irq1 masked");
   wake_gate_a: assert property (wakeup_out |-> ev_pd || $past(ev_pd) || $past(ev_pd, 2))
      else $error("stray wake");
   wake_once_a: assert property (wakeup_out |=> !wakeup_out) else $error("wake too long");
   run_hold0_a: assert property (rd_c0 |-> wb_dat_out[4] == c0_reg[4]) else $error("run bit changed");
   run_hold1_a: assert property (rd_ok && wb_adr_in == 8'h0C |-> wb_dat_out[4] == c1_reg[4])
      else $error("run1 bit changed");
endmodule
bind tec_timer_top tec_timer_monitor tec_timer_monitor_inst (.clk_sys_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
   .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .timer_event_pin_in,
   .ctr0_irq_out, .ctr1_irq_out, .wakeup_out);
`default_nettype wire

// file: verification/tec_pin_source.sv
// Purpose: External signal source on the timer pin
// Assumes: Levels last longer than two clocks
// Notes: Idles high; always driven
`timescale 1ns/10ps
`default_nettype none
module tec_pin_source (
   input wire logic clk_sys_in,
   output logic pin_out
);
   initial pin_out = 1'b1;
   task automatic drive(input logic lvl, input int hold);
      @(posedge clk_sys_in);
      pin_out <= lvl;
      repeat (hold) @(posedge clk_sys_in);
   endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the timer top
// Assumes: Counter 1 divider shortened to 8
// Notes: Bus tasks follow classic Wishbone
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk_sys_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, pin, wake_seen;
   logic [7:0] wb_adr_in;
   logic [3:0] wb_sel_in;
   logic [31:0] wb_dat_in, wb_dat_out;
   logic wb_ack_out, ctr0_irq_out, ctr1_irq_out, wakeup_out;
   int mismatches, comparisons;
   always #12.5 clk_sys_in = ~clk_sys_in;
   tec_timer_top #(.CTR0_DIV(4), .CTR1_DIV(8)) tec_timer_top_inst (.clk_sys_in, .rst_n_in, .wb_cyc_in,
      .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
      .timer_event_pin_in(pin), .ctr0_irq_out, .ctr1_irq_out, .wakeup_out);
   tec_pin_source tec_pin_source_inst (.clk_sys_in, .pin_out(pin));
   always @(posedge clk_sys_in) if (wakeup_out === 1'b1) wake_seen <= 1'b1;
   task automatic end_sim;
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_hi(ref logic s);
      for (int n = 0; n < 200 && s !== 1'b1; n++) @(posedge clk_sys_in);
      chk(32'(s), 32'h1);
      if (s !== 1'b1) end_sim();
   endtask
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      int n;
      @(posedge clk_sys_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= a;
      wb_dat_in <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 20);
      r = wb_dat_out[7:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      wb_we_in <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      xfer(1'b0, a, 8'h00, d);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd(a, v[15:8]);
      rd(a - 8'h04, v[7:0]);
   endtask
   task automatic wait_flag(input logic [7:0] m);
      logic [7:0] d;
      d = 8'h00;
      for (int n = 0; n < 100 && (d & m) == 8'h00; n++) rd(8'h18, d);
      chk(32'(d & m), 32'(m));
      if ((d & m) == 8'h00) end_sim();
   endtask
   task automatic t_reset;
      logic [7:0] d;
      logic [15:0] v;
      rd(8'h00, d);
      chk(32'(d), 32'h0);
      rd(8'h18, d);
      chk(32'(d), 32'h0);
      rd16(8'h14, v);
      chk(32'(v), 32'h0);
      wr(8'h40, 8'hFF);
      rd(8'h40, d);
      chk(32'(d), 32'h0);
   endtask
   task automatic t_timer0;
      logic [7:0] d;
      logic [15:0] v;
      wr(8'h00, 8'h80);
      wr(8'h04, 8'hF0);
      wr(8'h08, 8'hFF);
      rd16(8'h08, v);
      chk(32'(v), 32'hFFF0);
      wr(8'h00, 8'h90);
      wait_flag(8'h10);
      chk(32'(ctr0_irq_out), 32'h0);
      rd(8'h00, d);
      chk(32'(d), 32'h90);
      rd16(8'h08, v);
      chk(32'(v[15:8]), 32'hFF);
      wr(8'h18, 8'h01);
      repeat (2) @(posedge clk_sys_in);
      chk(32'(ctr0_irq_out), 32'h1);
      wr(8'h00, 8'h80);
      wr(8'h18, 8'h11);
      repeat (2) @(posedge clk_sys_in);
      chk(32'(ctr0_irq_out), 32'h0);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h90);
      repeat (200) @(posedge clk_sys_in);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'hFF);
      repeat (190) @(posedge clk_sys_in);
      wr(8'h00, 8'h80);
      rd16(8'h08, v);
      chk(32'(v >= 16'h0061 && v <= 16'h0066), 32'h1);
   endtask
   task automatic t_timer1;
      wr(8'h18, 8'h02);
      wr(8'h10, 8'hFE);
      wr(8'h14, 8'hFF);
      wr(8'h0C, 8'h80);
      wr(8'h0C, 8'h90);
      wait_hi(ctr1_irq_out);
      wr(8'h0C, 8'h00);
      // Enable stays on so that only the cleared flag can drop the request
      wr(8'h18, 8'h22);
      repeat (2) @(posedge clk_sys_in);
      chk(32'(ctr1_irq_out), 32'h0);
   endtask
   task automatic t_event;
      logic [15:0] v;
      wr(8'h18, 8'h01);
      wr(8'h00, 8'h40);
      wr(8'h04, 8'hFD);
      wr(8'h08, 8'hFF);
      wr(8'h00, 8'h50);
      tec_pin_source_inst.drive(1'b0, 6);
      tec_pin_source_inst.drive(1'b1, 6);
      rd16(8'h08, v);
      chk(32'(v), 32'hFFFE);
      wr(8'h00, 8'h58);
      tec_pin_source_inst.drive(1'b0, 6);
      tec_pin_source_inst.drive(1'b1, 6);
      rd16(8'h08, v);
      chk(32'(v), 32'hFFFF);
      chk(32'(wake_seen), 32'h0);
      wr(8'h1C, 8'h01);
      tec_pin_source_inst.drive(1'b0, 6);
      wait_hi(wake_seen);
      wait_flag(8'h10);
      rd16(8'h08, v);
      chk(32'(v), 32'hFFFD);
      wr(8'h1C, 8'h00);
      wr(8'h00, 8'h40);
      wr(8'h18, 8'h11);
   endtask
   task automatic t_pulse(input logic [7:0] c, input logic act);
      logic [7:0] d;
      logic [15:0] v, w;
      tec_pin_source_inst.drive(~act, 8);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h00, c);
      wr(8'h00, c | 8'h10);
      repeat (40) @(posedge clk_sys_in);
      rd16(8'h08, v);
      chk(32'(v), 32'h0);
      tec_pin_source_inst.drive(act, 80);
      tec_pin_source_inst.drive(~act, 20);
      rd(8'h00, d);
      chk(32'(d), 32'(c));
      rd16(8'h08, v);
      chk(32'(v >= 16'h0012 && v <= 16'h0016), 32'h1);
      tec_pin_source_inst.drive(act, 20);
      tec_pin_source_inst.drive(~act, 20);
      rd16(8'h08, w);
      chk(32'(w), 32'(v));
   endtask
   initial begin
      clk_sys_in = 1'b0;
      rst_n_in = 1'b0;
      {wb_cyc_in, wb_stb_in, wb_we_in, wake_seen} = 4'h0;
      wb_adr_in = 8'h00;
      wb_sel_in = 4'hF;
      wb_dat_in = 32'h0;
      mismatches = 0;
      comparisons = 0;
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_timer0();
      t_timer1();
      t_event();
      t_pulse(8'hC0, 1'b0);
      t_pulse(8'hC8, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
